// *** design/tpo_pkg.sv ***
package tpo_pkg;

	localparam int          TPO_CNT_W       = 16;
	localparam int          TPO_CAP_FILT    = 3;
	localparam logic [15:0] TPO_CNT_RST     = 16'h0000;
	localparam logic [15:0] TPO_CMP_RST     = 16'hFFFF;
	localparam logic [11:0] TPO_PRESCALE_DF = 12'h008;

	typedef enum logic [1:0] {
		TPO_MODE_TOGGLE,
		TPO_MODE_PWM,
		TPO_MODE_VPP,
		TPO_MODE_ONESHOT
	} tpo_mode_t;

	typedef struct packed {
		logic oneshot_set_bit;
		logic oneshot_reset_bit;
		logic output_enable_bit;
		logic active_level_bit;
	} tpo_chan_ctrl_t;

	typedef struct packed {
		logic [15:0] pre;
		logic [15:0] count;
		logic [15:0] capture;
		logic [1:0]  act;
		logic [1:0]  pin;
		logic [1:0]  irq;
		logic        cap_irq;
		logic        run_q;
	} tpo_state_t;

endpackage

// *** design/tpo_edge_filter.sv ***
`timescale 1ns/10ps

module tpo_edge_filter
	import tpo_pkg::*;
#(
	parameter int MIN_CLKS = TPO_CAP_FILT
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Raw input and filtered edge
	input  wire logic sig_i,
	output logic      edge_o
);

	typedef struct packed {
		logic       stable;
		logic       cand;
		logic [3:0] run;
		logic       edge_p;
	} tpo_filt_t;

	tpo_filt_t s_q;
	tpo_filt_t s_d;

	// Level must persist MIN_CLKS clocks before it counts as a new phase
	always_comb begin
		s_d        = s_q;
		s_d.edge_p = 1'b0;
		if (sig_i != s_q.cand) begin
			s_d.cand = sig_i;
			s_d.run  = 4'h1;
		end else if (s_q.run < 4'(MIN_CLKS)) begin
			s_d.run = s_q.run + 4'h1;
		end
		if (s_d.cand != s_q.stable && s_d.run >= 4'(MIN_CLKS)) begin
			s_d.stable = s_d.cand;
			s_d.edge_p = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign edge_o = s_q.edge_p;

endmodule

// *** design/tpo_timer.sv ***
`timescale 1ns/10ps

module tpo_timer
	import tpo_pkg::*;
#(
	parameter int          CNT_W    = TPO_CNT_W,
	parameter logic [15:0] PRESCALE = 16'(TPO_PRESCALE_DF)
) (
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Control
	input  wire logic           count_run_bit_i,
	input  wire tpo_mode_t      mode_i,
	input  wire logic           compare1_clear_enable_i,
	input  wire tpo_chan_ctrl_t ch0_ctrl_i,
	input  wire tpo_chan_ctrl_t ch1_ctrl_i,
	input  wire logic [15:0]    compare0_i,
	input  wire logic [15:0]    compare1_i,
	// Capture
	input  wire logic           capture_edge_input_i,
	output logic [15:0]         capture_register_o,
	output logic                capture_irq_o,
	// Status and outputs
	output logic [15:0]         count_register_o,
	output logic                compare0_match_irq_o,
	output logic                compare1_match_irq_o,
	output logic [1:0]          timer_output_pin_o
);

	tpo_state_t     s_q;
	tpo_state_t     s_d;
	logic           cap_edge;
	tpo_chan_ctrl_t ctl [2];
	logic [15:0]    cmp [2];
	logic           tick;
	logic [1:0]     match;

	assign ctl[0] = ch0_ctrl_i;
	assign ctl[1] = ch1_ctrl_i;
	assign cmp[0] = compare0_i;
	assign cmp[1] = compare1_i;

	tpo_edge_filter #(
		.MIN_CLKS (TPO_CAP_FILT)
	) u_filt (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.sig_i  (capture_edge_input_i),
		.edge_o (cap_edge)
	);

	// Active flag to pin level: enabled pin shows active bit when set
	function automatic logic pin_level(input tpo_chan_ctrl_t c, input logic act);
		if (!c.output_enable_bit) begin
			pin_level = ~c.active_level_bit;
		end else begin
			pin_level = act ? c.active_level_bit : ~c.active_level_bit;
		end
	endfunction

	// Compare 1 clears the count on the count clock after it is reached,
	// so a period of n lasts n+1 count clocks
	function automatic logic clears_on_top(input tpo_mode_t m, input logic clr_en);
		clears_on_top = clr_en || (m == TPO_MODE_VPP);
	endfunction

	function automatic logic [15:0] next_count(
		input logic [15:0] cnt,
		input logic [15:0] top,
		input logic        clr
	);
		if (clr && cnt == top) begin
			next_count = '0;
		end else begin
			next_count = cnt + 16'h0001;
		end
	endfunction

	// Prescaler end point: one count clock per PRESCALE system clocks
	function automatic logic prescale_done(input logic [15:0] pre);
		prescale_done = (pre >= PRESCALE - 16'h0001);
	endfunction

	// Pulse modulation: active from count zero until the match
	function automatic logic pwm_next(
		input logic act,
		input logic hit,
		input logic wrap
	);
		if (hit) begin
			pwm_next = 1'b0;
		end else if (wrap) begin
			pwm_next = 1'b1;
		end else begin
			pwm_next = act;
		end
	endfunction

	// One-shot: set wins over reset, a match ends the pulse
	function automatic logic oneshot_next(
		input tpo_chan_ctrl_t c,
		input logic           act,
		input logic           hit
	);
		if (c.oneshot_set_bit) begin
			oneshot_next = 1'b1;
		end else if (c.oneshot_reset_bit) begin
			oneshot_next = 1'b0;
		end else if (hit) begin
			oneshot_next = 1'b0;
		end else begin
			oneshot_next = act;
		end
	endfunction

	function automatic logic toggle_next(input logic act, input logic hit);
		toggle_next = hit ? ~act : act;
	endfunction

	always_comb begin
		logic [15:0] nxt;
		nxt   = '0;
		s_d   = s_q;
		s_d.irq     = 2'b00;
		s_d.cap_irq = 1'b0;
		s_d.run_q   = count_run_bit_i;
		tick  = 1'b0;
		match = 2'b00;
		// Prescaler gives one count clock every PRESCALE system clocks
		if (count_run_bit_i) begin
			if (prescale_done(s_q.pre)) begin
				s_d.pre = '0;
				tick    = 1'b1;
			end else begin
				s_d.pre = s_q.pre + 16'h0001;
			end
		end else begin
			s_d.pre = '0;
		end
		// Match is seen only on a count clock, when the counter increments or clears
		if (tick) begin
			nxt = next_count(s_q.count, cmp[1],
				clears_on_top(mode_i, compare1_clear_enable_i));
			for (int i = 0; i < 2; i++) begin
				match[i] = (nxt == cmp[i]);
			end
			s_d.count = nxt;
			s_d.irq   = match;
		end
		unique case (mode_i)
			TPO_MODE_TOGGLE: begin
				for (int i = 0; i < 2; i++) begin
					s_d.act[i] = toggle_next(s_q.act[i], match[i]);
				end
			end
			TPO_MODE_PWM: begin
				// Active from zero to compare, one compare per channel, shared period
				for (int i = 0; i < 2; i++) begin
					s_d.act[i] = pwm_next(s_q.act[i], match[i], tick && nxt == '0);
				end
				if (!count_run_bit_i) begin
					s_d.act = 2'b11;
				end
			end
			TPO_MODE_VPP: begin
				// Period on compare 1 clear, width on compare 0
				s_d.act[0] = pwm_next(s_q.act[0], match[0], tick && nxt == '0);
				s_d.act[1] = 1'b0;
				if (!count_run_bit_i) begin
					s_d.act[0] = 1'b1;
				end
			end
			TPO_MODE_ONESHOT: begin
				for (int i = 0; i < 2; i++) begin
					s_d.act[i] = oneshot_next(ctl[i], s_q.act[i], match[i] && count_run_bit_i);
				end
				// Stopped counter gives no match, so level holds
			end
		endcase
		for (int i = 0; i < 2; i++) begin
			s_d.pin[i] = pin_level(ctl[i], s_d.act[i]);
		end
		if (cap_edge) begin
			s_d.capture = s_q.count;
			s_d.cap_irq = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q       <= '0;
			s_q.count <= TPO_CNT_RST;
			s_q.pin   <= 2'b11;
		end else begin
			s_q <= s_d;
		end
	end

	assign count_register_o     = s_q.count;
	assign capture_register_o   = s_q.capture;
	assign capture_irq_o        = s_q.cap_irq;
	assign compare0_match_irq_o = s_q.irq[0];
	assign compare1_match_irq_o = s_q.irq[1];
	assign timer_output_pin_o   = s_q.pin;

endmodule

// *** verif/tpo_chk.sv ***
`timescale 1ns/10ps
module tpo_chk
	import tpo_pkg::*;
(
	// Watched ports
	input wire logic           clk_i,
	input wire logic           rst_i,
	input wire logic           count_run_bit_i,
	input wire tpo_mode_t      mode_i,
	input wire logic           compare1_clear_enable_i,
	input wire tpo_chan_ctrl_t ch0_ctrl_i,
	input wire logic [15:0]    compare1_i,
	input wire logic           capture_edge_input_i,
	input wire logic           capture_irq_o,
	input wire logic [15:0]    count_register_o,
	input wire logic           compare0_match_irq_o,
	input wire logic [1:0]     timer_output_pin_o
);
	wire        os = mode_i == TPO_MODE_ONESHOT;
	wire        en = ch0_ctrl_i.output_enable_bit;
	wire        al = ch0_ctrl_i.active_level_bit;
	wire        st = ch0_ctrl_i.oneshot_set_bit;
	wire        p0 = timer_output_pin_o[0];
	wire        e  = capture_edge_input_i;
	wire [15:0] c  = count_register_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_DIS: assert property (!$past(rst_i) && $past(!en) |-> p0 != $past(al))
		else $error("idle level");
	AST_SET: assert property (os && en && st |=> p0 == al)
		else $error("start level");
	AST_END: assert property (compare0_match_irq_o && $past(os && en && !st) |-> p0 != al)
		else $error("end level");
	AST_HLD: assert property (os && en && p0 != al && !st |=> p0 != al)
		else $error("hold level");
	AST_VPP: assert property (mode_i == TPO_MODE_VPP && en && !count_run_bit_i |=> p0 == al)
		else $error("stop level");
	AST_CNT: assert property ($changed(c) && c != 16'h0 |-> c == $past(c) + 16'h1)
		else $error("count step");
	AST_CLR: assert property (compare1_clear_enable_i && $changed(c) && $past(c) == compare1_i |-> c == 16'h0)
		else $error("count clear");
	AST_FLT: assert property (capture_irq_o |-> $past(e) == $past(e, 2) && $past(e, 2) == $past(e, 3))
		else $error("short phase");
endmodule
bind tpo_timer tpo_chk chk_u (.*);

// *** verif/tpo_src.sv ***
`timescale 1ns/10ps
module tpo_src (
	// Clock and pulse line
	input  wire logic clk_i,
	output logic      sig_o
);
	initial sig_o = 1'b0;
	// High for w clocks, then low
	task automatic pulse(input int w);
		@(posedge clk_i);
		#1 sig_o = 1'b1;
		repeat (w) @(posedge clk_i);
		#1 sig_o = 1'b0;
	endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, x, a) begin num_checks++; if ((a) !== (x)) begin bad_count++; $display("Error %s exp %h got %h", n, x, a); end end
module tb_top
	import tpo_pkg::*;
;
	logic           clk_i = 1'b0;
	logic           rst_i = 1'b1;
	logic           count_run_bit_i = 1'b0;
	logic           compare1_clear_enable_i = 1'b1;
	tpo_mode_t      mode_i = TPO_MODE_ONESHOT;
	tpo_chan_ctrl_t ch0_ctrl_i = 4'b0001;
	tpo_chan_ctrl_t ch1_ctrl_i = 4'b0000;
	logic [15:0]    compare0_i = 16'h0014;
	logic [15:0]    compare1_i = 16'h0028;
	logic [15:0]    capture_register_o, count_register_o, cap_a;
	logic           capture_edge_input_i, capture_irq_o;
	logic           compare0_match_irq_o, compare1_match_irq_o;
	logic [1:0]     timer_output_pin_o;
	int             bad_count = 0, num_checks = 0, caps = 0, n;
	tpo_timer #(.PRESCALE(16'h0001)) dut_u (.*);
	tpo_src src_u (.clk_i, .sig_o(capture_edge_input_i));
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (capture_irq_o === 1'b1) caps <= caps + 1;
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	task automatic await(ref logic s);
		n = 0;
		while (s !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
	endtask
	// Never set and reset in one write
	task automatic os(input bit ch, input bit rs);
		if (ch) ch1_ctrl_i[3-rs] = 1'b1;
		else ch0_ctrl_i[3-rs] = 1'b1;
		tick(1);
		ch0_ctrl_i[3:2] = 2'b00;
		ch1_ctrl_i[3:2] = 2'b00;
		tick(1);
	endtask
	task automatic stop_test();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		tick(3);
		rst_i = 1'b0;
		tick(2);
		`CHK("pin_off", 2'b10, timer_output_pin_o)
		ch0_ctrl_i = 4'b0011;
		ch1_ctrl_i = 4'b0010;
		count_run_bit_i = 1'b1;
		tick(5);
		os(0, 0);
		`CHK("os_start", 2'b11, timer_output_pin_o)
		await(compare0_match_irq_o);
		`CHK("os_end", 2'b10, timer_output_pin_o)
		`CHK("match", 16'h0014, count_register_o)
		tick(50);
		`CHK("os_hold", 2'b10, timer_output_pin_o)
		os(1, 0);
		`CHK("os1_start", 2'b00, timer_output_pin_o)
		os(1, 1);
		`CHK("os1_kill", 2'b10, timer_output_pin_o)
		os(0, 0);
		count_run_bit_i = 1'b0;
		tick(50);
		`CHK("frozen", 2'b11, timer_output_pin_o)
		count_run_bit_i = 1'b1;
		await(compare1_match_irq_o);
		tick(1);
		await(compare1_match_irq_o);
		`CHK("period", 41, n + 1)
		mode_i = TPO_MODE_VPP;
		tick(45);
		await(compare0_match_irq_o);
		tick(2);
		`CHK("vpp_low", 1'b0, timer_output_pin_o[0])
		count_run_bit_i = 1'b0;
		tick(3);
		`CHK("vpp_stop", 1'b1, timer_output_pin_o[0])
		mode_i = TPO_MODE_PWM;
		count_run_bit_i = 1'b1;
		await(compare1_match_irq_o);
		tick(1);
		await(compare0_match_irq_o);
		`CHK("pwm_mid", 2'b00, timer_output_pin_o)
		tick(1);
		await(compare1_match_irq_o);
		`CHK("pwm_end", 2'b10, timer_output_pin_o)
		count_run_bit_i = 1'b0;
		tick(2);
		`CHK("pwm_stop", 2'b01, timer_output_pin_o)
		mode_i = TPO_MODE_TOGGLE;
		compare1_clear_enable_i = 1'b0;
		count_run_bit_i = 1'b1;
		src_u.pulse(2);
		tick(8);
		`CHK("glitch", 0, caps)
		src_u.pulse(10);
		cap_a = capture_register_o;
		tick(8);
		`CHK("width", 16'h000A, capture_register_o - cap_a)
		`CHK("caps", 2, caps)
		compare0_i = count_register_o + 16'h0020;
		tick(1);
		await(compare0_match_irq_o);
		compare0_i = compare0_i + 16'h0010;
		tick(1);
		await(compare0_match_irq_o);
		`CHK("interval", 16, n + 1)
		stop_test();
	end
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
endmodule
